// ### include/hcp_pkg.sv
package hcp_pkg;

    // host interface style, taken from the mode strap pins
    localparam logic [1:0] HCP_MODE_SERIAL  = 2'h0;
    localparam logic [1:0] HCP_MODE_STYLE_A = 2'h1;
    localparam logic [1:0] HCP_MODE_STYLE_B = 2'h2;

    // serial frame: command byte (read flag, 7 address bits), then data byte
    localparam logic [4:0] HCP_SER_LAST_CMD = 5'h07;
    localparam logic [4:0] HCP_SER_LAST_BIT = 5'h0F;
    localparam logic [4:0] HCP_SER_FRAME    = 5'h10;
    localparam int         HCP_SER_RD_BIT   = 7;

    // values after reset
    localparam logic       HCP_READY_RST = 1'b1;
    localparam logic       HCP_ACK_N_RST = 1'b1;
    localparam logic [7:0] HCP_BYTE_RST  = 8'h00;

    typedef struct packed {
        logic       cs_n;
        logic       ale;
        logic       as_n;
        logic       rd_n;
        logic       wr_n;
        logic       ds_n;
        logic       rw;
        logic [1:0] mode;
        logic [7:0] ad;
    } hcp_pins_t;

    localparam int HCP_PINS_W = $bits(hcp_pins_t);
    localparam int HCP_SYNC_W = HCP_PINS_W + 1;

    // idle pin levels: deselected, strobes released
    localparam hcp_pins_t HCP_PINS_RST = '{cs_n: 1'b1, ale: 1'b0, as_n: 1'b1,
        rd_n: 1'b1, wr_n: 1'b1, ds_n: 1'b1, rw: 1'b0, mode: 2'h0, ad: 8'h00};

    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hcp_req_t;

    localparam hcp_req_t HCP_REQ_RST = '{we: 1'b0, re: 1'b0, addr: 8'h00, wdata: 8'h00};

    typedef enum logic [2:0] {
        HCP_IDLE,
        HCP_PAR_RD,
        HCP_PAR_DRIVE,
        HCP_WR_WAIT,
        HCP_PAR_DONE,
        HCP_SER_RD,
        HCP_SER_HOLD
    } hcp_state_t;

endpackage

// ### verilog/hcp_sync.sv
`timescale 1ns/10ps
module hcp_sync
    import hcp_pkg::*;
#(
    parameter int                  WIDTH   = HCP_SYNC_W,
    parameter logic [WIDTH-1:0]    RST_VAL = '0
)
(
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // stage1 feeds sync_out only; nothing else may look at it
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    stage1[i]   <= RST_VAL[i];
                    sync_out[i] <= RST_VAL[i];
                end else begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate

endmodule

// ### verilog/hcp_port.sv
`timescale 1ns/10ps
module hcp_port
    import hcp_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       sclk,
    input  wire logic       chip_sel_n,
    input  wire logic [1:0] host_mode,
    input  wire logic       serial_in,
    input  wire logic       out_edge_select,
    output logic            serial_out,
    input  wire logic       addr_latch_en,
    input  wire logic       addr_latch_strobe_b,
    input  wire logic       rd_strobe_n,
    input  wire logic       wr_strobe_n,
    input  wire logic       data_strobe_n,
    input  wire logic       read_not_write,
    input  wire logic [7:0] ad_in,
    output logic      [7:0] ad_out,
    output logic            ad_oe,
    output logic            ready,
    output logic            ack_n,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_we,
    output logic            reg_re,
    input  wire logic [7:0] reg_rdata
);

    // ---------------- serial side, on sclk, cleared by chip select -------
    logic [4:0]  bit_cnt;
    logic [7:0]  in_sh;
    logic [7:0]  ser_cmd;
    logic [7:0]  ser_wdata;
    logic        ser_req;
    logic        ack_s1;
    logic        ack_s2;
    logic        esel_s1;
    logic        esel_s2;
    logic        out_started;
    logic [7:0]  out_sh;
    logic        out_pos;
    logic        out_neg;
    logic [7:0]  next_byte;
    logic        cmd_done;
    logic        wr_done;
    logic        load_out;

    // ---------------- system side ----------------------------------------
    logic [HCP_SYNC_W-1:0] sync_in;
    logic [HCP_SYNC_W-1:0] sync_q;
    hcp_pins_t   pin;
    hcp_pins_t   prev;
    logic        s_req;
    hcp_state_t  state;
    hcp_state_t  next_state;
    hcp_req_t    req;
    hcp_req_t    next_req;
    logic [7:0]  par_addr;
    logic [7:0]  next_par_addr;
    logic        ser_ack;
    logic        next_ser_ack;
    logic [7:0]  ser_rdata;
    logic [7:0]  next_ser_rdata;
    logic [7:0]  next_ad_out;
    logic        next_ad_oe;
    logic        next_ready;
    logic        next_ack_n;
    logic        cs_on;
    logic        style_a;
    logic        style_b;
    logic        serial_mode;
    logic        ale_fall;
    logic        as_fall;
    logic        rd_fall;
    logic        wr_fall;
    logic        ds_fall;
    logic        strobe_low;

    assign next_byte = {in_sh[6:0], serial_in};
    assign cmd_done  = (bit_cnt == HCP_SER_LAST_CMD);
    assign wr_done   = (bit_cnt == HCP_SER_LAST_BIT) && !ser_cmd[HCP_SER_RD_BIT];
    assign load_out  = ser_cmd[HCP_SER_RD_BIT] && ser_req && ack_s2 && !out_started;

    // chip select high ends the frame even if sclk has already stopped
    always_ff @(posedge sclk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            bit_cnt   <= 5'h00;
            in_sh     <= HCP_BYTE_RST;
            ser_cmd   <= HCP_BYTE_RST;
            ser_wdata <= HCP_BYTE_RST;
            ser_req   <= 1'b0;
        end else begin
            in_sh <= next_byte;
            if (bit_cnt != HCP_SER_FRAME) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
            if (cmd_done) begin
                ser_cmd <= next_byte;
                ser_req <= next_byte[HCP_SER_RD_BIT];
            end
            if (wr_done) begin
                ser_wdata <= next_byte;
                ser_req   <= 1'b1;
            end
        end
    end

    always_ff @(posedge sclk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            ack_s1  <= 1'b0;
            ack_s2  <= 1'b0;
            esel_s1 <= 1'b0;
            esel_s2 <= 1'b0;
        end else begin
            ack_s1  <= ser_ack;
            ack_s2  <= ack_s1;
            esel_s1 <= out_edge_select;
            esel_s2 <= esel_s1;
        end
    end

    // read reply: low until data is in, a one as start bit, then 8 bits msb first;
    // ser_rdata is stable while the synchronised ack is high
    always_ff @(posedge sclk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            out_started <= 1'b0;
            out_sh      <= HCP_BYTE_RST;
            out_pos     <= 1'b0;
        end else if (load_out) begin
            out_started <= 1'b1;
            out_sh      <= ser_rdata;
            out_pos     <= 1'b1;
        end else if (out_started) begin
            out_pos <= out_sh[7];
            out_sh  <= {out_sh[6:0], 1'b0};
        end
    end

    always_ff @(negedge sclk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            out_neg <= 1'b0;
        end else begin
            out_neg <= out_pos;
        end
    end

    // both sources are flip-flops; the strap only picks which edge launches
    assign serial_out = esel_s2 ? out_neg : out_pos;

    // ---------------- pin capture into clk_sys ---------------------------
    assign sync_in = {ser_req, chip_sel_n, addr_latch_en, addr_latch_strobe_b,
                      rd_strobe_n, wr_strobe_n, data_strobe_n, read_not_write,
                      host_mode, ad_in};

    hcp_sync #(
        .WIDTH   (HCP_SYNC_W),
        .RST_VAL ({1'b0, HCP_PINS_RST})
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .async_in (sync_in),
        .sync_out (sync_q)
    );

    assign s_req       = sync_q[HCP_PINS_W];
    assign pin         = hcp_pins_t'(sync_q[HCP_PINS_W-1:0]);
    assign cs_on       = !pin.cs_n;
    assign style_a     = (pin.mode == HCP_MODE_STYLE_A);
    assign style_b     = (pin.mode == HCP_MODE_STYLE_B);
    assign serial_mode = (pin.mode == HCP_MODE_SERIAL);
    assign ale_fall    = prev.ale && !pin.ale;
    assign as_fall     = prev.as_n && !pin.as_n;
    assign rd_fall     = prev.rd_n && !pin.rd_n;
    assign wr_fall     = prev.wr_n && !pin.wr_n;
    assign ds_fall     = prev.ds_n && !pin.ds_n;
    assign strobe_low  = style_a ? !pin.rd_n : !pin.ds_n;

    // address phase: pin and bus are delayed alike, so the edge sees its own address
    assign next_par_addr = (cs_on && ((style_a && ale_fall) || (style_b && as_fall)))
                         ? pin.ad : par_addr;

    always_comb begin
        next_state     = state;
        next_req       = req;
        next_req.we    = 1'b0;
        next_req.re    = 1'b0;
        next_ser_ack   = ser_ack;
        next_ser_rdata = ser_rdata;
        next_ad_out    = ad_out;
        next_ad_oe     = ad_oe;
        next_ready     = ready;
        next_ack_n     = ack_n;
        unique case (state)
            HCP_IDLE: begin
                if (cs_on && style_a && rd_fall) begin
                    next_req.re   = 1'b1;
                    next_req.addr = par_addr;
                    next_ready    = 1'b0;
                    next_state    = HCP_PAR_RD;
                end else if (cs_on && style_a && wr_fall) begin
                    next_ready = 1'b0;
                    next_state = HCP_WR_WAIT;
                end else if (cs_on && style_b && ds_fall && pin.rw) begin
                    next_req.re   = 1'b1;
                    next_req.addr = par_addr;
                    next_state    = HCP_PAR_RD;
                end else if (cs_on && style_b && ds_fall) begin
                    next_req.we    = 1'b1;
                    next_req.addr  = par_addr;
                    next_req.wdata = pin.ad;
                    next_ack_n     = 1'b0;
                    next_state     = HCP_PAR_DONE;
                end else if (serial_mode && s_req && !ser_ack) begin
                    next_req.addr  = {1'b0, ser_cmd[6:0]};
                    next_req.wdata = ser_wdata;
                    if (ser_cmd[HCP_SER_RD_BIT]) begin
                        next_req.re = 1'b1;
                        next_state  = HCP_SER_RD;
                    end else begin
                        next_req.we  = 1'b1;
                        next_ser_ack = 1'b1;
                        next_state   = HCP_SER_HOLD;
                    end
                end
            end
            HCP_PAR_RD: begin
                next_ad_out = reg_rdata;
                next_ready  = 1'b1;
                if (cs_on && strobe_low) begin
                    next_ad_oe = 1'b1;
                    next_ack_n = !style_b;
                    next_state = HCP_PAR_DRIVE;
                end else begin
                    next_state = HCP_IDLE;
                end
            end
            HCP_PAR_DRIVE: begin
                // release as soon as the strobe or select goes away
                if (!cs_on || !strobe_low) begin
                    next_ad_oe = 1'b0;
                    next_ack_n = 1'b1;
                    next_state = HCP_IDLE;
                end
            end
            HCP_WR_WAIT: begin
                // the last bus value seen with the strobe still low is the data
                if (pin.wr_n) begin
                    next_req.we    = 1'b1;
                    next_req.addr  = par_addr;
                    next_req.wdata = prev.ad;
                    next_ready     = 1'b1;
                    next_state     = HCP_IDLE;
                end
            end
            HCP_PAR_DONE: begin
                if (pin.ds_n) begin
                    next_ack_n = 1'b1;
                    next_state = HCP_IDLE;
                end
            end
            HCP_SER_RD: begin
                next_ser_rdata = reg_rdata;
                next_ser_ack   = 1'b1;
                next_state     = HCP_SER_HOLD;
            end
            HCP_SER_HOLD: begin
                if (!s_req) begin
                    next_ser_ack = 1'b0;
                    next_state   = HCP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state     <= HCP_IDLE;
            prev      <= HCP_PINS_RST;
            req       <= HCP_REQ_RST;
            par_addr  <= HCP_BYTE_RST;
            ser_ack   <= 1'b0;
            ser_rdata <= HCP_BYTE_RST;
            ad_out    <= HCP_BYTE_RST;
            ad_oe     <= 1'b0;
            ready     <= HCP_READY_RST;
            ack_n     <= HCP_ACK_N_RST;
        end else begin
            state     <= next_state;
            prev      <= pin;
            req       <= next_req;
            par_addr  <= next_par_addr;
            ser_ack   <= next_ser_ack;
            ser_rdata <= next_ser_rdata;
            ad_out    <= next_ad_out;
            ad_oe     <= next_ad_oe;
            ready     <= next_ready;
            ack_n     <= next_ack_n;
        end
    end

    assign reg_we    = req.we;
    assign reg_re    = req.re;
    assign reg_addr  = req.addr;
    assign reg_wdata = req.wdata;

    // ---------------- checks --------------------------------------------
    AST_SER_SAMPLE: assert property (@(posedge sclk) disable iff (chip_sel_n)
        1'b1 |=> in_sh[0] == $past(serial_in))
        else $error("serial input bit not taken on rising sclk");

    AST_SER_START: assert property (@(posedge sclk) disable iff (chip_sel_n)
        load_out |=> out_pos ##1 (out_pos == $past(out_sh[7])))
        else $error("serial reply start bit or first data bit wrong");

    AST_ADDR_A: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (cs_on && style_a && ale_fall) |=> par_addr == $past(pin.ad))
        else $error("address not latched at falling latch enable");

    AST_ADDR_B: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (cs_on && style_b && as_fall) |=> par_addr == $past(pin.ad))
        else $error("address not latched at falling address strobe");

    AST_OE_STROBE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ad_oe |-> !prev.cs_n && (style_a ? !prev.rd_n : !prev.ds_n))
        else $error("bus driven without a read strobe");

    AST_TURNAROUND: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ad_oe && (!cs_on || !strobe_low)) |=> !ad_oe)
        else $error("bus still driven after strobe release");

    AST_READY_BUSY: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state == HCP_IDLE && cs_on && style_a && wr_fall) |=> !ready [*2])
        else $error("ready not low during write");

    AST_WRITE_A: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state == HCP_WR_WAIT && pin.wr_n) |=> ready && reg_we && reg_wdata == $past(prev.ad))
        else $error("style A write not completed with strobe data");

    AST_ACK_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state == HCP_IDLE && cs_on && style_b && ds_fall && !pin.rw)
        |=> reg_we && !ack_n && reg_wdata == $past(pin.ad))
        else $error("style B write not acknowledged");

    AST_B_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state == HCP_IDLE && cs_on && style_b && ds_fall && pin.rw && !serial_mode)
        |=> reg_re ##1 (ad_out == $past(reg_rdata)) && (ad_oe == !ack_n))
        else $error("style B read data or ack wrong");

endmodule

// ### bench/hcp_host.sv
`timescale 1ns/10ps
module hcp_host
    import hcp_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_oe,
    input  wire logic       serial_out,
    output hcp_pins_t       pins,
    output logic            host_oe,
    output logic      [7:0] ad_in,
    output logic            sclk,
    output logic            serial_in,
    output logic            clash
);
    logic [7:0] last_ad;

    // a released bus shows the inverse of its last level, so stale data never passes
    assign ad_in = ad_oe ? ad_out : (host_oe ? pins.ad : ~last_ad);
    assign clash = ad_oe & host_oe;

    initial begin
        pins      = HCP_PINS_RST;
        pins.cs_n = 1'b0;
        host_oe   = 1'b0;
        last_ad   = 8'h00;
        sclk      = 1'b0;
        serial_in = 1'b0;
        // a clean rise of chip select clears the link-side flops at start of run
        #1;
        pins.cs_n = 1'b1;
    end

    always @(posedge clk_sys) begin
        last_ad <= ad_in;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic par_begin(input logic styleb, input logic rd, input logic cs_v,
                             input logic [7:0] addr, input logic [7:0] data);
        pins.mode <= styleb ? HCP_MODE_STYLE_B : HCP_MODE_STYLE_A;
        pins.cs_n <= cs_v;
        pins.ad   <= addr;
        host_oe   <= 1'b1;
        cyc(1);
        pins.as_n <= ~styleb;
        pins.ale  <= ~styleb;
        cyc(6);
        pins.ale  <= 1'b0;
        pins.as_n <= 1'b1;
        cyc(5);
        pins.ad   <= data;
        host_oe   <= ~rd;
        pins.rw   <= rd;
        cyc(1);
        pins.ds_n <= ~styleb;
        pins.rd_n <= styleb | ~rd;
        pins.wr_n <= styleb | rd;
    endtask

    task automatic par_end();
        cyc(6);
        pins.ds_n <= 1'b1;
        pins.rd_n <= 1'b1;
        pins.wr_n <= 1'b1;
        // data and select held 500 ns past the strobe rise
        cyc(5);
        host_oe   <= 1'b0;
        pins.cs_n <= 1'b1;
        pins.rw   <= 1'b0;
        cyc(5);
    endtask

    task automatic ser_open();
        pins.mode <= HCP_MODE_SERIAL;
        cyc(4);
        pins.cs_n <= 1'b0;
        cyc(2);
        #3;
    endtask

    // serial_in moves only while sclk is low, the device takes it on the rise
    task automatic sbit(input logic din, output logic q_r, output logic q_f,
                        output logic st_r, output logic st_f);
        serial_in = din;
        #6.5;
        q_r = serial_out;
        sclk = 1'b1;
        #1;
        st_r = (serial_out === q_r);
        #6.5;
        q_f = serial_out;
        sclk = 1'b0;
        #1;
        st_f = (serial_out === q_f);
    endtask

    task automatic ser_close();
        cyc(8);
        pins.cs_n <= 1'b1;
        cyc(8);
    endtask
endmodule

// ### bench/hcp_port_tb.sv
`timescale 1ns/10ps
module hcp_port_tb
    import hcp_pkg::*;
();
    logic       clk_sys = 1'b0;
    logic       rst_b = 1'b0;
    logic       out_edge_select = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] we_count = 8'h00;
    logic [7:0] clashes = 8'h00;
    logic [7:0] mem [256];
    logic [7:0] exp_mem [256];
    logic [7:0] last_wa = 8'h00;
    logic [7:0] last_wd = 8'h00;
    hcp_pins_t  pins;
    logic       host_oe, sclk, serial_in, clash, serial_out, ad_oe, ready, ack_n;
    logic       reg_we, reg_re;
    logic [7:0] ad_in, ad_out, reg_addr, reg_wdata;
    int         bad_count = 0;
    int         num_checks = 0;

    always #50 clk_sys = ~clk_sys;

    hcp_port i_hcp_port (.clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk),
        .chip_sel_n(pins.cs_n), .host_mode(pins.mode), .serial_in(serial_in),
        .out_edge_select(out_edge_select), .serial_out(serial_out),
        .addr_latch_en(pins.ale), .addr_latch_strobe_b(pins.as_n), .rd_strobe_n(pins.rd_n),
        .wr_strobe_n(pins.wr_n), .data_strobe_n(pins.ds_n), .read_not_write(pins.rw),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .ready(ready), .ack_n(ack_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata));

    hcp_host i_hcp_host (.clk_sys(clk_sys), .ad_out(ad_out), .ad_oe(ad_oe),
        .serial_out(serial_out), .pins(pins), .host_oe(host_oe), .ad_in(ad_in),
        .sclk(sclk), .serial_in(serial_in), .clash(clash));

    // core model: read data is valid only while the read pulse stands, garbage otherwise;
    // the port takes it at the edge that ends the pulse
    assign reg_rdata = (reg_re === 1'b1) ? mem[reg_addr] : ~mem[reg_addr];

    always @(posedge clk_sys) begin
        if (reg_we === 1'b1) begin
            mem[reg_addr] <= reg_wdata;
            last_wa       <= reg_addr;
            last_wd       <= reg_wdata;
            we_count      <= we_count + 8'h01;
        end
        if (clash === 1'b1) begin
            clashes <= clashes + 8'h01;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check_bit(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    function automatic logic pick(input int s);
        return (s == 0) ? ready : ((s == 1) ? ack_n : ad_oe);
    endfunction

    // answers lag the strobes by the pin synchronisers, so allow a few cycles
    task automatic wait_lvl(input int s, input logic lvl);
        int n;
        n = 0;
        #1;
        while (pick(s) !== lvl && n < 12) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    task automatic t_reset_vals();
        check_bit(ready, HCP_READY_RST);
        check_bit(ack_n, HCP_ACK_N_RST);
        check_bit(ad_oe, 1'b0);
        check_bit(serial_out, 1'b0);
    endtask

    task automatic t_a_write(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] cnt;
        cnt = we_count;
        i_hcp_host.par_begin(1'b0, 1'b0, 1'b0, a, d);
        wait_lvl(0, 1'b0);
        check_bit(ready, 1'b0);
        i_hcp_host.par_end();
        check_bit(ready, 1'b1);
        check(we_count, cnt + 8'h01);
        check(last_wa, a);
        check(last_wd, d);
        exp_mem[a] = d;
    endtask

    task automatic t_a_read(input logic [7:0] a);
        i_hcp_host.par_begin(1'b0, 1'b1, 1'b0, a, 8'h00);
        check_bit(ad_oe, 1'b0);
        wait_lvl(2, 1'b1);
        check_bit(ad_oe, 1'b1);
        check(ad_in, exp_mem[a]);
        check_bit(ready, 1'b1);
        i_hcp_host.par_end();
        check_bit(ad_oe, 1'b0);
    endtask

    task automatic t_b_write(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] cnt;
        cnt = we_count;
        i_hcp_host.par_begin(1'b1, 1'b0, 1'b0, a, d);
        wait_lvl(1, 1'b0);
        check_bit(ack_n, 1'b0);
        i_hcp_host.par_end();
        check_bit(ack_n, 1'b1);
        check(we_count, cnt + 8'h01);
        check(last_wa, a);
        check(last_wd, d);
        exp_mem[a] = d;
    endtask

    task automatic t_b_read(input logic [7:0] a);
        i_hcp_host.par_begin(1'b1, 1'b1, 1'b0, a, 8'h00);
        wait_lvl(1, 1'b0);
        check_bit(ack_n, 1'b0);
        check_bit(ad_oe, 1'b1);
        check(ad_in, exp_mem[a]);
        i_hcp_host.par_end();
        check_bit(ad_oe, 1'b0);
        check_bit(ack_n, 1'b1);
    endtask

    task automatic t_refused(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] cnt;
        cnt = we_count;
        i_hcp_host.par_begin(1'b1, 1'b0, 1'b1, a, d);
        repeat (8) @(posedge clk_sys);
        #1;
        check_bit(ack_n, 1'b1);
        i_hcp_host.par_end();
        check(we_count, cnt);
    endtask

    task automatic t_ser_write(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] frame;
        logic [7:0]  cnt;
        logic        qr, qf, sr, sf;
        frame = {1'b0, a, d};
        cnt   = we_count;
        i_hcp_host.ser_open();
        for (int i = 15; i >= 0; i--) begin
            i_hcp_host.sbit(frame[i], qr, qf, sr, sf);
        end
        i_hcp_host.ser_close();
        check(we_count, cnt + 8'h01);
        check(last_wa, {1'b0, a});
        check(last_wd, d);
        exp_mem[{1'b0, a}] = d;
    endtask

    task automatic t_ser_read(input logic [6:0] a, input logic sel);
        logic [7:0] cmd, got;
        logic       qr, qf, sr, sf, q;
        int         n;
        cmd = {1'b1, a};
        @(posedge clk_sys);
        out_edge_select <= sel;
        i_hcp_host.ser_open();
        for (int i = 7; i >= 0; i--) begin
            i_hcp_host.sbit(cmd[i], qr, qf, sr, sf);
        end
        q = 1'b0;
        n = 0;
        while (q !== 1'b1 && n < 120) begin
            i_hcp_host.sbit(1'b0, qr, qf, sr, sf);
            q = sel ? qr : qf;
            n++;
        end
        check_bit(q, 1'b1);
        for (int i = 7; i >= 0; i--) begin
            i_hcp_host.sbit(1'b0, qr, qf, sr, sf);
            got[i] = sel ? qr : qf;
            check_bit(sel ? sr : sf, 1'b1);
        end
        i_hcp_host.ser_close();
        check(got, exp_mem[{1'b0, a}]);
    endtask

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i]     = 8'(i) ^ 8'hA5;
            exp_mem[i] = 8'(i) ^ 8'hA5;
        end
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        t_reset_vals();
        t_a_write(8'h3C, 8'hC3);
        t_a_read(8'h3C);
        t_a_read(8'h80);
        t_b_write(8'hFF, 8'h5A);
        t_b_read(8'hFF);
        t_b_read(8'h01);
        t_refused(8'h10, 8'hEE);
        t_ser_write(7'h21, 8'h96);
        t_b_read(8'h21);
        t_ser_read(7'h3C, 1'b1);
        t_ser_read(7'h55, 1'b0);
        t_a_write(8'h00, 8'hFF);
        check(clashes, 8'h00);
        wrap_up();
    end

    // all accesses take well under 100 us
    initial begin
        #500000;
        bad_count++;
        wrap_up();
    end
endmodule
